// *** vic_map.svh ***
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit apb bus, one 8-bit register per byte offset except the wider pending and status words, some sharing a word
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

`define VIC_IE_OFF        8'hA8
`define VIC_PRIO_LO_OFF   8'hB8
`define VIC_PRIO_HI_OFF   8'h84
`define VIC_EIE1_OFF      8'hE6
`define VIC_EXTENDED_ENABLE_REG_2_OFF      8'hE7
`define VIC_EIP1_OFF      8'hF6
`define VIC_EIP1H_OFF     8'hF5
`define VIC_EIP2_OFF      8'hF7
`define VIC_EIP2H_OFF     8'hF4
`define VIC_PEND_OFF      8'hC0
`define VIC_STAT_OFF      8'hC4
`define VIC_IE_RESET      8'h00
`define VIC_GLOBAL_BIT    7
`define VIC_NSRC          19
`define VIC_RESERVED_SRC  13
`define VIC_VEC_BASE      16'h0003
`define VIC_VEC_STEP      16'h0008
`define VIC_DETECT_CYC    1
`define VIC_CALL_CYC      4
`define VIC_BEST_LAT      5
`define VIC_WORST_LAT     18

`endif

// *** vic_pkg.sv ***
// types shared by the interrupt controller files
// assumes vic_map.svh is compiled alongside
package vic_pkg;
   typedef logic [1:0]  vic_prio_type;
   typedef logic [15:0] vic_vec_type;
   typedef enum logic [1:0] {
      VIC_IDLE,
      VIC_WAIT_BOUNDARY,
      VIC_CALL,
      VIC_HOLD_ONE
   } vic_state_type;
endpackage

// *** vic_arbiter.sv ***
// priority arbiter over all request lines
// assumes requests already gated by enables, same clock
`timescale 1ns/1ns
`include "vic_map.svh"
module vic_arbiter #(
   parameter int NSRC = `VIC_NSRC
) (
   input  wire logic [NSRC-1:0]   req,
   input  wire logic [2*NSRC-1:0] prio,
   output logic                   win_valid,
   output logic [4:0]             win_id,
   output vic_pkg::vic_prio_type  win_prio
);
   import vic_pkg::*;

   // highest level, then lowest order
   always_comb begin
      win_valid = 1'b0;
      win_id    = 5'h00;
      win_prio  = 2'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i] && (!win_valid || prio[2*i +: 2] >= win_prio)) begin
            win_valid = 1'b1;
            win_id    = 5'(i);
            win_prio  = prio[2*i +: 2];
         end
      end
   end
endmodule

// *** vic_level_stack.sv ***
// stack of active priority levels, one bit per level
// assumes push and pop come from the controller on the same clock
`timescale 1ns/1ns
module vic_level_stack (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  push,
   input  wire vic_pkg::vic_prio_type push_level,
   input  wire logic                  pop,
   output logic                       active,
   output vic_pkg::vic_prio_type      level
);
   import vic_pkg::*;
   logic [3:0] busy;
   logic [3:0] next_busy;

   always_comb begin
      next_busy = busy;
      if (pop) begin
         next_busy[level] = 1'b0;
      end
      if (push) begin
         next_busy[push_level] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 4'h0;
      end else begin
         busy <= next_busy;
      end
   end

   always_comb begin
      active = |busy;
      level  = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (busy[i]) begin
            level = 2'(i);
         end
      end
   end
endmodule

// *** vic_controller.sv ***
// vectored interrupt controller: enables, priorities, arbitration, call
// assumes an apb master, a core giving instruction boundaries and returns
//
// Functional notes
// - pending flags sampled and arbitrated every clock cycle
// - best case five cycles: one detect plus four call cycles
// - after a return, one more instruction completes before the call
// - worst case eighteen cycles with return then divide
// - equal or higher active level holds new requests off
// - at routine exit the highest pending request is taken next
// - vector is 0x0003 plus eight times order; order 13 reserved
// - equal levels resolved by lower fixed order number
// - global enable bit seven overrides every individual mask
// - enable bits zero to six mask the seven primary sources
// - timer 2 enable gates both low and high overflow flags
// - spi enable gates all four spi flags together
// - timer 0, timer 1 and ext irq 1 enables gate their flags
// - primary enable register resets to zero
// - only ext irq and timer 0/1 flags auto clear on vectoring
// - two-bit priority from high and low register bits, reset zero
// - strictly higher level preempts; top level never preempted
// - flags set by events regardless of enable; write one sets
`timescale 1ns/1ns
`include "vic_map.svh"
module vic_controller #(
   parameter int NSRC = `VIC_NSRC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_irq_pin_0,
   input  wire logic        external_irq_pin_1_n,
   input  wire logic [NSRC-1:0] src_event,
   input  wire logic        instr_boundary,
   input  wire logic        return_from_isr_instr,
   output logic             long_call_to_vector,
   output vic_pkg::vic_vec_type call_vector,
   output logic [4:0]       call_source,
   output logic             isr_active
);
   import vic_pkg::*;

   logic [7:0]      interrupt_enable_mask;
   logic [7:0]      prio_lo;
   logic [7:0]      prio_hi;
   logic [7:0]      ext_en1;
   logic [7:0]      extended_enable_reg_2;
   logic [7:0]      ext_pl1;
   logic [7:0]      ext_ph1;
   logic [7:0]      ext_pl2;
   logic [7:0]      ext_ph2;
   logic [NSRC-1:0] pend;
   logic [3:0]      spi_flags;
   logic [1:0]      tmr2_flags;
   logic [1:0]      pin0_sync;
   logic [1:0]      pin1_sync;
   logic            pin0_prev;
   logic [7:0]      next_ie;
   logic [7:0]      next_prio_lo;
   logic [7:0]      next_prio_hi;
   logic [7:0]      next_ext_en1;
   logic [7:0]      next_ext_en2;
   logic [7:0]      next_ext_pl1;
   logic [7:0]      next_ext_ph1;
   logic [7:0]      next_ext_pl2;
   logic [7:0]      next_ext_ph2;
   logic [NSRC-1:0] next_pend;
   logic [3:0]      next_spi_flags;
   logic [1:0]      next_tmr2_flags;
   logic [NSRC-1:0] src_en;
   logic [NSRC-1:0] req;
   logic [2*NSRC-1:0] prio;
   logic            win_valid;
   logic [4:0]      win_id;
   vic_prio_type    win_prio;
   logic            lvl_active;
   vic_prio_type    lvl;
   logic            allow;
   vic_state_type   state;
   vic_state_type   next_state;
   logic [1:0]      call_cnt;
   logic [1:0]      next_call_cnt;
   logic [4:0]      next_call_source;
   vic_prio_type    call_prio;
   vic_prio_type    next_call_prio;
   logic            wr;
   logic            rd;
   logic            push;
   logic            ack;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;

   // enable mapping per source
   always_comb begin
      src_en = '0;
      src_en[6:0]   = interrupt_enable_mask[6:0];
      src_en[7]     = ext_en1[0];
      src_en[8]     = ext_en1[1];
      src_en[9]     = ext_en1[2];
      src_en[10]    = ext_en1[3];
      src_en[11]    = ext_en1[4];
      src_en[12]    = ext_en1[5];
      src_en[14]    = ext_en1[7];
      src_en[18:15] = extended_enable_reg_2[3:0];
      for (int i = 0; i < NSRC; i++) begin
         if (i < 7) begin
            prio[2*i +: 2] = {prio_hi[i], prio_lo[i]};
         end else if (i < 15) begin
            prio[2*i +: 2] = {ext_ph1[i-7], ext_pl1[i-7]};
         end else begin
            prio[2*i +: 2] = {ext_ph2[i-15], ext_pl2[i-15]};
         end
      end
   end

   always_comb begin
      req = pend & src_en & {NSRC{interrupt_enable_mask[`VIC_GLOBAL_BIT]}};
      req[`VIC_RESERVED_SRC] = 1'b0;
   end

   vic_arbiter #(.NSRC(NSRC)) u_arb (
      .req       (req),
      .prio      (prio),
      .win_valid (win_valid),
      .win_id    (win_id),
      .win_prio  (win_prio)
   );

   assign allow = win_valid && (!lvl_active || win_prio > lvl);

   assign ack  = (state == VIC_CALL) && (call_cnt == 2'(`VIC_CALL_CYC - 1));
   assign push = ack;
   assign long_call_to_vector = (state == VIC_CALL);

   vic_level_stack u_stack (
      .pclk       (pclk),
      .presetn    (presetn),
      .push       (push),
      .push_level (call_prio),
      .pop        (return_from_isr_instr && instr_boundary),
      .active     (lvl_active),
      .level      (lvl)
   );
   assign isr_active = lvl_active;

   // register writes and pending flags
   always_comb begin
      next_ie         = interrupt_enable_mask;
      next_prio_lo    = prio_lo;
      next_prio_hi    = prio_hi;
      next_ext_en1    = ext_en1;
      next_ext_en2    = extended_enable_reg_2;
      next_ext_pl1    = ext_pl1;
      next_ext_ph1    = ext_ph1;
      next_ext_pl2    = ext_pl2;
      next_ext_ph2    = ext_ph2;
      next_pend       = pend;
      next_spi_flags  = spi_flags;
      next_tmr2_flags = tmr2_flags;
      if (ack && (call_source <= 5'h03)) begin
         next_pend[call_source] = 1'b0;
      end
      if (wr) begin
         unique case (paddr)
            `VIC_IE_OFF:      next_ie      = pwdata[7:0];
            `VIC_PRIO_LO_OFF: next_prio_lo = pwdata[7:0];
            `VIC_PRIO_HI_OFF: next_prio_hi = pwdata[7:0];
            `VIC_EIE1_OFF:    next_ext_en1 = pwdata[7:0];
            `VIC_EXTENDED_ENABLE_REG_2_OFF:    next_ext_en2 = pwdata[7:0];
            `VIC_EIP1_OFF:    next_ext_pl1 = pwdata[7:0];
            `VIC_EIP1H_OFF:   next_ext_ph1 = pwdata[7:0];
            `VIC_EIP2_OFF:    next_ext_pl2 = pwdata[7:0];
            `VIC_EIP2H_OFF:   next_ext_ph2 = pwdata[7:0];
            `VIC_PEND_OFF:    next_pend    = pwdata[NSRC-1:0];
            default:          next_ie      = interrupt_enable_mask;
         endcase
      end
      next_pend = next_pend | src_event;
      // pin 0 rising edge, pin 1 active low level
      if (pin0_sync[1] && !pin0_prev) begin
         next_pend[0] = 1'b1;
      end
      if (!pin1_sync[1]) begin
         next_pend[2] = 1'b1;
      end
      // timer 2 low or high flag
      if (src_event[5]) begin
         next_tmr2_flags = 2'h3;
      end
      next_pend[5] = next_pend[5] | (|next_tmr2_flags);
      if (wr && paddr == `VIC_PEND_OFF && !pwdata[5]) begin
         next_tmr2_flags = 2'h0;
      end
      // four spi flags share one request
      if (src_event[6]) begin
         next_spi_flags = 4'hF;
      end
      next_pend[6] = next_pend[6] | (|next_spi_flags);
      if (wr && paddr == `VIC_PEND_OFF && !pwdata[6]) begin
         next_spi_flags = 4'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable_mask <= `VIC_IE_RESET;
         prio_lo               <= 8'h00;
         prio_hi               <= 8'h00;
         ext_en1               <= 8'h00;
         extended_enable_reg_2 <= 8'h00;
         ext_pl1               <= 8'h00;
         ext_ph1               <= 8'h00;
         ext_pl2               <= 8'h00;
         ext_ph2               <= 8'h00;
         pend                  <= '0;
         spi_flags             <= 4'h0;
         tmr2_flags            <= 2'h0;
         pin0_sync             <= 2'h0;
         pin1_sync             <= 2'h3;
         pin0_prev             <= 1'b0;
      end else begin
         interrupt_enable_mask <= next_ie;
         prio_lo               <= next_prio_lo;
         prio_hi               <= next_prio_hi;
         ext_en1               <= next_ext_en1;
         extended_enable_reg_2 <= next_ext_en2;
         ext_pl1               <= next_ext_pl1;
         ext_ph1               <= next_ext_ph1;
         ext_pl2               <= next_ext_pl2;
         ext_ph2               <= next_ext_ph2;
         pend                  <= next_pend;
         spi_flags             <= next_spi_flags;
         tmr2_flags            <= next_tmr2_flags;
         pin0_sync             <= {pin0_sync[0], external_irq_pin_0};
         pin1_sync             <= {pin1_sync[0], external_irq_pin_1_n};
         pin0_prev             <= pin0_sync[1];
      end
   end

   // read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rd) begin
         pslverr <= 1'b0;
         unique case (paddr)
            `VIC_IE_OFF:      prdata <= {24'h0, interrupt_enable_mask};
            `VIC_PRIO_LO_OFF: prdata <= {24'h0, 1'b1, prio_lo[6:0]};
            `VIC_PRIO_HI_OFF: prdata <= {24'h0, 1'b1, prio_hi[6:0]};
            `VIC_EIE1_OFF:    prdata <= {24'h0, ext_en1};
            `VIC_EXTENDED_ENABLE_REG_2_OFF:    prdata <= {24'h0, extended_enable_reg_2};
            `VIC_EIP1_OFF:    prdata <= {24'h0, ext_pl1};
            `VIC_EIP1H_OFF:   prdata <= {24'h0, ext_ph1};
            `VIC_EIP2_OFF:    prdata <= {24'h0, ext_pl2};
            `VIC_EIP2H_OFF:   prdata <= {24'h0, ext_ph2};
            `VIC_PEND_OFF:    prdata <= {13'h0, pend};
            `VIC_STAT_OFF:    prdata <= {21'h0, lvl_active, lvl,
                                         win_valid, call_source, 2'h0};
            default: begin
               prdata  <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   // call sequencer
   always_comb begin
      next_state       = state;
      next_call_cnt    = call_cnt;
      next_call_source = call_source;
      next_call_prio   = call_prio;
      unique case (state)
         VIC_IDLE: begin
            if (return_from_isr_instr && instr_boundary && win_valid) begin
               next_state = VIC_HOLD_ONE;
            end else if (allow && instr_boundary) begin
               next_state       = VIC_CALL;
               next_call_cnt    = 2'h0;
               next_call_source = win_id;
               next_call_prio   = win_prio;
            end
         end
         VIC_HOLD_ONE: begin
            if (instr_boundary) begin
               next_state = VIC_WAIT_BOUNDARY;
            end
         end
         VIC_WAIT_BOUNDARY: begin
            if (allow) begin
               next_state       = VIC_CALL;
               next_call_cnt    = 2'h0;
               next_call_source = win_id;
               next_call_prio   = win_prio;
            end else begin
               next_state = VIC_IDLE;
            end
         end
         VIC_CALL: begin
            next_call_cnt = call_cnt + 2'h1;
            if (ack) begin
               next_state = VIC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= VIC_IDLE;
         call_cnt    <= 2'h0;
         call_source <= 5'h00;
         call_prio   <= 2'h0;
      end else begin
         state       <= next_state;
         call_cnt    <= next_call_cnt;
         call_source <= next_call_source;
         call_prio   <= next_call_prio;
      end
   end

   assign call_vector = `VIC_VEC_BASE + (16'(call_source) << 3);

   AST_CALL_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(long_call_to_vector) |-> long_call_to_vector [*4] ##1
      !long_call_to_vector) else $error("call not four cycles");
   AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      long_call_to_vector |-> call_vector == 16'h0003 + 16'(call_source) * 8)
      else $error("bad vector");
   AST_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
      !interrupt_enable_mask[7] |-> !win_valid)
      else $error("request with global off");
   AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
      long_call_to_vector |-> call_source != 5'd13)
      else $error("reserved vector");
   AST_PREEMPT: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(long_call_to_vector) && $past(lvl_active) |->
      call_prio > $past(lvl)) else $error("illegal preempt");
   AST_AUTOCLR: assert property (@(posedge pclk) disable iff (!presetn)
      ack && call_source > 5'h03 && !wr |=> pend[$past(call_source)])
      else $error("flag cleared by vectoring");
   AST_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      src_event[1] |=> pend[1]) else $error("event lost");
   AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      state == VIC_HOLD_ONE |-> !long_call_to_vector)
      else $error("call before next instruction");
   COV_CALL: cover property (@(posedge pclk) $rose(long_call_to_vector));
   COV_NEST: cover property (@(posedge pclk)
      $rose(long_call_to_vector) && lvl_active);
   COV_RETURN_FROM_ISR_INSTR: cover property (@(posedge pclk) state == VIC_HOLD_ONE);
endmodule

// *** vic_core_model.sv ***
// stand-in for the cpu core: retires instructions and issues returns
// assumes the controller call output is a registered level
`timescale 1ns/1ns
module vic_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       long_call_to_vector,
   input  wire logic [3:0] instr_len,
   input  wire logic       ret_req,
   output logic            instr_boundary,
   output logic            return_from_isr_instr
);
   logic [3:0] cnt;
   logic       ret_pend;

   // no instruction retires while the call is in flight
   assign instr_boundary = !long_call_to_vector &&
                           (cnt == instr_len - 4'h1);
   assign return_from_isr_instr = instr_boundary && ret_pend;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 4'h0;
         ret_pend <= 1'b0;
      end else begin
         if (!long_call_to_vector)
            cnt <= instr_boundary ? 4'h0 : cnt + 4'h1;
         if (ret_req)
            ret_pend <= 1'b1;
         else if (return_from_isr_instr)
            ret_pend <= 1'b0;
      end
   end
endmodule

// *** vectored_interrupt_controller_tb.sv ***
// self-checking bench for the interrupt controller
// assumes vic_core_model stands in for the core
`timescale 1ns/1ns
`include "vic_map.svh"
module vectored_interrupt_controller_tb;
   import vic_pkg::*;
`define CHK(g, e, m) begin n_checks++; \
   if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t %s", $time, m); end end
   logic        pclk      = 1'b0;
   logic        presetn   = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic        pin0      = 1'b0;
   logic        pin1_n    = 1'b1;
   logic [18:0] src_event = 19'h0;
   logic [3:0]  instr_len = 4'h1;
   logic        ret_req   = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ib;
   logic        ret_i;
   logic        call;
   vic_vec_type call_vector;
   logic [4:0]  call_source;
   logic        isr_active;
   int          n_errors  = 0;
   int          n_checks  = 0;
   int          cyc       = 0;
   int          ord[11]   = '{0, 1, 2, 3, 4, 5, 6, 15, 16, 17, 18};

   always #2 pclk = ~pclk;

   vic_controller dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_irq_pin_0(pin0),
      .external_irq_pin_1_n(pin1_n), .src_event(src_event),
      .instr_boundary(ib), .return_from_isr_instr(ret_i),
      .long_call_to_vector(call), .call_vector(call_vector),
      .call_source(call_source), .isr_active(isr_active));

   vic_core_model core_u (
      .pclk(pclk), .presetn(presetn), .long_call_to_vector(call),
      .instr_len(instr_len), .ret_req(ret_req), .instr_boundary(ib),
      .return_from_isr_instr(ret_i));

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         conclude;
      end
   end

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic pulse(input logic [18:0] m);
      src_event <= m;
      @(posedge pclk);
      src_event <= 19'h0;
   endtask

   task automatic wait_call(input int lim, output int n);
      n = 0;
      do begin @(posedge pclk); n++; end
      while (call !== 1'b1 && n < lim);
   endtask

   task automatic drop;
      while (call === 1'b1) @(posedge pclk);
   endtask

   task automatic ret;
      drop;
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
      do @(posedge pclk); while (ret_i !== 1'b1);
      @(posedge pclk);
   endtask

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      apb(1'b0, `VIC_IE_OFF, 32'h0, r, e);
      `CHK(r[7:0], `VIC_IE_RESET, "enable reset")
      apb(1'b0, `VIC_PRIO_LO_OFF, 32'h0, r, e);
      `CHK(r[7:0], 8'h80, "prio low reset")
      apb(1'b0, `VIC_PRIO_HI_OFF, 32'h0, r, e);
      `CHK(r[7:0], 8'h80, "prio high reset")
      apb(1'b0, 8'h10, 32'h0, r, e);
      `CHK({e, r}, {1'b1, 32'h0}, "unmapped read")
      wr(`VIC_IE_OFF, 32'h55);
      apb(1'b0, `VIC_IE_OFF, 32'h0, r, e);
      `CHK(r[7:0], 8'h55, "enable readback")
      wr(`VIC_IE_OFF, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_mask;
      logic [31:0] r;
      logic        e;
      int          n;
      wr(`VIC_IE_OFF, 32'h7F);
      pulse(19'h00002);
      wait_call(20, n);
      `CHK(call, 1'b0, "call with global off")
      apb(1'b0, `VIC_PEND_OFF, 32'h0, r, e);
      `CHK(r[1], 1'b1, "flag set while masked")
      wr(`VIC_IE_OFF, 32'h82);
      wait_call(20, n);
      `CHK(call_source, 5'h01, "timer0 source")
      drop;
      repeat (2) @(posedge pclk);
      apb(1'b0, `VIC_PEND_OFF, 32'h0, r, e);
      `CHK(r[1], 1'b0, "timer0 flag auto clear")
      wr(`VIC_IE_OFF, 32'h0);
      ret;
      $display("test mask done");
   endtask

   task automatic t_best;
      int n;
      int m;
      wr(`VIC_IE_OFF, 32'h81);
      pulse(19'h00001);
      wait_call(10, n);
      `CHK(n, `VIC_DETECT_CYC + 1, "detect latency")
      m = 0;
      while (call === 1'b1) begin @(posedge pclk); m++; end
      `CHK(m, `VIC_CALL_CYC, "call length")
      wr(`VIC_IE_OFF, 32'h0);
      ret;
      `CHK(isr_active, 1'b0, "level released")
      $display("test best done");
   endtask

   task automatic t_vectors;
      logic [31:0] r;
      logic        e;
      int          n;
      int          i;
      foreach (ord[k]) begin
         i = ord[k];
         if (i < 7)
            wr(`VIC_IE_OFF, 32'h80 | (32'h1 << i));
         else begin
            wr(`VIC_IE_OFF, 32'h80);
            wr(`VIC_EXTENDED_ENABLE_REG_2_OFF, 32'h1 << (i - 15));
         end
         if (i == 2)
            pin1_n <= 1'b0;
         else if (i == 0)
            pin0 <= 1'b1;
         else
            pulse(19'h00001 << i);
         wait_call(30, n);
         pin1_n <= 1'b1;
         pin0 <= 1'b0;
         `CHK(call_vector, `VIC_VEC_BASE + `VIC_VEC_STEP * 16'(i), "vec")
         `CHK(call_source, 5'(i), "source")
         drop;
         repeat (2) @(posedge pclk);
         apb(1'b0, `VIC_PEND_OFF, 32'h0, r, e);
         if (i > 3)
            `CHK(r[i], 1'b1, "flag kept")
         else if (i != 2)
            `CHK(r[i], 1'b0, "flag cleared")
         wr(`VIC_PEND_OFF, 32'h0);
         wr(`VIC_IE_OFF, 32'h0);
         wr(`VIC_EXTENDED_ENABLE_REG_2_OFF, 32'h0);
         ret;
      end
      $display("test vectors done");
   endtask

   task automatic t_tie(input logic [31:0] plo, input logic [4:0] s0,
                        input logic [4:0] s1);
      int n;
      wr(`VIC_PRIO_LO_OFF, plo);
      wr(`VIC_IE_OFF, 32'h8A);
      pulse(19'h0000A);
      wait_call(20, n);
      `CHK(call_source, s0, "first winner")
      ret;
      wait_call(20, n);
      `CHK(call_source, s1, "next pending")
      ret;
      wr(`VIC_IE_OFF, 32'h0);
      wr(`VIC_PRIO_LO_OFF, 32'h0);
      $display("test tie done");
   endtask

   task automatic t_hold;
      int n;
      wr(`VIC_IE_OFF, 32'h83);
      pulse(19'h00001);
      wait_call(10, n);
      drop;
      pulse(19'h00002);
      wait_call(15, n);
      `CHK(call, 1'b0, "equal level held off")
      instr_len <= 4'h8;
      ret;
      wait_call(30, n);
      `CHK(n >= 8 && n <= `VIC_WORST_LAT, 1'b1, "one instr")
      `CHK(call_source, 5'h01, "held source")
      wr(`VIC_PRIO_LO_OFF, 32'h01);
      instr_len <= 4'h1;
      pulse(19'h00001);
      wait_call(30, n);
      `CHK(call_source, 5'h00, "preempt source")
      ret;
      ret;
      wr(`VIC_PRIO_LO_OFF, 32'h0);
      wr(`VIC_IE_OFF, 32'h0);
      `CHK(isr_active, 1'b0, "all levels released")
      $display("test hold done");
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_mask;
      t_best;
      t_vectors;
      t_tie(32'h00, 5'h01, 5'h03);
      t_tie(32'h08, 5'h03, 5'h01);
      t_hold;
      conclude;
   end
endmodule
